// *** rtl/spsel_consts.vh ***
// Constants for the speed profile and start select block.
// Assumes inclusion by the design file and the testbench files.
`ifndef SPSEL_CONSTS_VH
`define SPSEL_CONSTS_VH
// Register byte offsets
`define SPSEL_ADR_CTRL 8'h00
`define SPSEL_ADR_DIGSPD 8'h04
`define SPSEL_ADR_LOW 8'h08
`define SPSEL_ADR_LOWSPD 8'h0c
`define SPSEL_ADR_UP 8'h10
`define SPSEL_ADR_UPSPD 8'h14
`define SPSEL_ADR_PT0 8'h18
`define SPSEL_ADR_STATUS 8'h2c
`define SPSEL_ADR_SPDREF 8'h30
`define SPSEL_NPTS 7
// Control fields
`define SPSEL_B_SERSEL 0
`define SPSEL_B_WAKECFG 1
`define SPSEL_F_PROF_LO 2
`define SPSEL_F_PROF_HI 3
`define SPSEL_B_RESYNC 4
`define SPSEL_B_ISD 5
`define SPSEL_B_BRAKE 6
`define SPSEL_F_INIT_LO 7
`define SPSEL_F_INIT_HI 8
`define SPSEL_CTRL_RST 9'h000
`define SPSEL_UPOFF_RST 16'hffff
// Profile codes
`define SPSEL_PROF_LIN 2'h0
`define SPSEL_PROF_STAIR 2'h1
`define SPSEL_PROF_FR 2'h2
// Motor state codes from detection
`define SPSEL_MOT_STOP 2'h0
`define SPSEL_MOT_FWD 2'h1
`define SPSEL_MOT_REV 2'h2
// Start path codes
`define SPSEL_ST_IDLE 3'h0
`define SPSEL_ST_DETECT 3'h1
`define SPSEL_ST_WAITSTOP 3'h2
`define SPSEL_ST_INIT 3'h3
`define SPSEL_ST_OPENLOOP 3'h4
`define SPSEL_ST_CLOSED 3'h5
`define SPSEL_ZERO16 16'h0000
`endif

// *** rtl/spsel_top.v ***
// Speed command conditioning and start path selection, with Wishbone slave.
// Assumes a 125 MHz clock; the wake pin passes through a 3-stage synchroniser.
// Summary of operation
// - Serial speed select set to 1 takes speed from the serial register.
// - In serial mode the digital speed register is the duty command.
// - In serial mode the speed pin wakes from sleep if configured.
// - Wake enters standby and locks speed to the digital register.
// - Profile 0 maps duty to speed with the linear profile.
// - Profile 1 maps duty to speed with the staircase profile.
// - Profile 2 is forward-reverse; duty also sets direction.
// - Duty below lower off threshold means off, lower off speed.
// - Running resumes only when duty rises above lower on threshold.
// - Between lower off and lower clamp, output lower clamp speed.
// - Linear profile interpolates clamp1, A..E, clamp2 breakpoints.
// - Above upper clamp duty the speed reference stays constant.
// - Above upper off: off, upper off speed; rerun below upper on.
// - Staircase steps the speed at each breakpoint, no interpolation.
// - Forward-reverse reverses direction when duty crosses point C.
// - Forward-reverse: interpolate clamp1 to A, hold A to B, off from B to D.
// - Reverse above D: hold D to E, interpolate D to clamp2, upper hysteresis.
// - Forward spinning motor with resync enabled goes straight closed-loop.
// - Resync disabled: coast or brake to stop, then start as stationary.
// - Stationary start uses align, double align, inductive detect or slow cycle.
// - After stationary initialisation, proceed to open-loop acceleration.
// - Initial speed detect runs only if enabled; else brake to stop if braking is set, or start as stationary.
// - Reverse spinning without reverse drive: coast or brake, then start.
`timescale 1ns/1ns
`include "spsel_consts.vh"
module spsel_top
(
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Speed pin path
    input wire [15:0] pin_duty_i,
    input wire speed_wake_pin_i,
    input wire sleep_i,
    // Start sequencing
    input wire start_i,
    input wire detect_done_i,
    input wire [1:0] motor_state_i,
    input wire motor_stopped_i,
    input wire init_done_i,
    input wire handoff_i,
    // Outputs
    output reg [15:0] speed_ref_o,
    output reg reverse_o,
    output reg motor_off_o,
    output reg standby_o,
    output reg [2:0] start_state_o,
    output reg brake_o,
    output reg [1:0] init_method_o
);
    reg [8:0] ctrl_reg;
    reg [15:0] dig_speed_reg;
    reg [15:0] low_off_duty_reg, low_on_duty_reg, low_off_speed_reg, low_clamp_speed_reg;
    reg [15:0] up_off_duty_reg, up_on_duty_reg, up_off_speed_reg;
    // Breakpoints: 0 clamp1, 1..5 A..E, 6 clamp2
    reg [15:0] pt_duty_reg [0:`SPSEL_NPTS-1];
    reg [15:0] pt_speed_reg [0:`SPSEL_NPTS-1];
    reg [2:0] wake_sync_reg;
    reg wake_latch_reg;
    reg low_off_reg, up_off_reg;
    reg [2:0] st_reg;
    reg [2:0] st_next;
    reg [15:0] duty;
    reg [15:0] ref_next;
    reg rev_next;
    reg off_next;
    reg low_off_next, up_off_next;
    reg [15:0] d0, d1, s0, s1;
    reg [31:0] rd;
    integer i, j, k;
    wire serial_mode = ctrl_reg[`SPSEL_B_SERSEL];
    wire [1:0] prof = ctrl_reg[`SPSEL_F_PROF_HI:`SPSEL_F_PROF_LO];
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Write lands at the edge where the master sees ack, not earlier
    wire wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    // Wake edge seen only once stages two and three agree
    wire wake_evt = wake_sync_reg[2] & wake_sync_reg[1];

    // Linear interpolation between two breakpoints; 32-bit product, 16-bit result
    function [15:0] spsel_interp;
        input [15:0] x, xa, xb, ya, yb;
        reg [31:0] p;
        reg [15:0] dx, dy, q;
        begin
            dx = xb - xa;
            dy = (yb >= ya) ? (yb - ya) : (ya - yb);
            if (dx == `SPSEL_ZERO16)
                q = `SPSEL_ZERO16;
            else
            begin
                p = (x - xa) * dy;
                p = p / {16'h0000, dx};
                q = p[15:0];
            end
            spsel_interp = (yb >= ya) ? (ya + q) : (ya - q);
        end
    endfunction

    // Register writes, byte lanes honoured for the control register only
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= `SPSEL_CTRL_RST;
            dig_speed_reg <= `SPSEL_ZERO16;
            low_off_duty_reg <= `SPSEL_ZERO16;
            low_on_duty_reg <= `SPSEL_ZERO16;
            low_off_speed_reg <= `SPSEL_ZERO16;
            low_clamp_speed_reg <= `SPSEL_ZERO16;
            up_off_duty_reg <= `SPSEL_UPOFF_RST;
            up_on_duty_reg <= `SPSEL_UPOFF_RST;
            up_off_speed_reg <= `SPSEL_ZERO16;
            for (i = 0; i < `SPSEL_NPTS; i = i + 1)
            begin
                pt_duty_reg[i] <= `SPSEL_ZERO16;
                pt_speed_reg[i] <= `SPSEL_ZERO16;
            end
        end
        else if (wb_wr)
        begin
            case (wb_adr_i)
                `SPSEL_ADR_CTRL:
                begin
                    if (wb_sel_i[0])
                        ctrl_reg[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        ctrl_reg[8] <= wb_dat_i[8];
                end
                `SPSEL_ADR_DIGSPD:
                    dig_speed_reg <= wb_dat_i[15:0];
                `SPSEL_ADR_LOW:
                begin
                    low_off_duty_reg <= wb_dat_i[15:0];
                    low_on_duty_reg <= wb_dat_i[31:16];
                end
                `SPSEL_ADR_LOWSPD:
                begin
                    low_off_speed_reg <= wb_dat_i[15:0];
                    low_clamp_speed_reg <= wb_dat_i[31:16];
                end
                `SPSEL_ADR_UP:
                begin
                    up_off_duty_reg <= wb_dat_i[15:0];
                    up_on_duty_reg <= wb_dat_i[31:16];
                end
                `SPSEL_ADR_UPSPD:
                    up_off_speed_reg <= wb_dat_i[15:0];
                default:
                begin
                    for (i = 0; i < `SPSEL_NPTS; i = i + 1)
                        if (wb_adr_i == `SPSEL_ADR_PT0 + i[7:0] * 8'h04)
                        begin
                            pt_duty_reg[i] <= wb_dat_i[15:0];
                            pt_speed_reg[i] <= wb_dat_i[31:16];
                        end
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read zero but still ack
    always @*
    begin
        rd = 32'h00000000;
        case (wb_adr_i)
            `SPSEL_ADR_CTRL: rd = {23'h000000, ctrl_reg};
            `SPSEL_ADR_DIGSPD: rd = {16'h0000, dig_speed_reg};
            `SPSEL_ADR_LOW: rd = {low_on_duty_reg, low_off_duty_reg};
            `SPSEL_ADR_LOWSPD: rd = {low_clamp_speed_reg, low_off_speed_reg};
            `SPSEL_ADR_UP: rd = {up_on_duty_reg, up_off_duty_reg};
            `SPSEL_ADR_UPSPD: rd = {16'h0000, up_off_speed_reg};
            `SPSEL_ADR_STATUS:
                rd = {24'h000000, wake_latch_reg, standby_o, motor_off_o, reverse_o,
                    brake_o, start_state_o};
            `SPSEL_ADR_SPDREF: rd = {16'h0000, speed_ref_o};
            default:
            begin
                for (j = 0; j < `SPSEL_NPTS; j = j + 1)
                    if (wb_adr_i == `SPSEL_ADR_PT0 + j[7:0] * 8'h04)
                        rd = {pt_speed_reg[j], pt_duty_reg[j]};
            end
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd : 32'h00000000;
        end
    end

    // Wake pin handling
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wake_sync_reg <= 3'h0;
            wake_latch_reg <= 1'b0;
            standby_o <= 1'b0;
        end
        else
        begin
            wake_sync_reg <= {wake_sync_reg[1:0], speed_wake_pin_i};
            if (serial_mode & ctrl_reg[`SPSEL_B_WAKECFG] & sleep_i & wake_evt)
            begin
                standby_o <= 1'b1;
                wake_latch_reg <= 1'b1;
            end
            else if (~serial_mode)
            begin
                wake_latch_reg <= 1'b0;
                standby_o <= 1'b0;
            end
            else if (~sleep_i)
                standby_o <= 1'b0;
        end
    end

    // Duty source, segment search and profile evaluation
    always @*
    begin
        duty = (serial_mode | wake_latch_reg) ? dig_speed_reg : pin_duty_i;
        d0 = pt_duty_reg[0];
        d1 = pt_duty_reg[1];
        s0 = pt_speed_reg[0];
        s1 = pt_speed_reg[1];
        for (k = 1; k < `SPSEL_NPTS - 1; k = k + 1)
            if (duty >= pt_duty_reg[k])
            begin
                d0 = pt_duty_reg[k];
                d1 = pt_duty_reg[k+1];
                s0 = pt_speed_reg[k];
                s1 = pt_speed_reg[k+1];
            end
        // Hysteresis on both off bands
        low_off_next = low_off_reg ? (duty <= low_on_duty_reg) : (duty < low_off_duty_reg);
        up_off_next = up_off_reg ? (duty >= up_on_duty_reg) : (duty > up_off_duty_reg);
        rev_next = 1'b0;
        off_next = low_off_next | up_off_next;
        ref_next = `SPSEL_ZERO16;
        case (prof)
            `SPSEL_PROF_LIN, `SPSEL_PROF_STAIR:
            begin
                if (low_off_next)
                    ref_next = low_off_speed_reg;
                else if (up_off_next)
                    ref_next = up_off_speed_reg;
                else if (duty < pt_duty_reg[0])
                    ref_next = low_clamp_speed_reg;
                else if (duty >= pt_duty_reg[`SPSEL_NPTS-1])
                    ref_next = pt_speed_reg[`SPSEL_NPTS-1];
                else if (prof == `SPSEL_PROF_LIN)
                    ref_next = spsel_interp(duty, d0, d1, s0, s1);
                else
                    ref_next = s0;
            end
            `SPSEL_PROF_FR:
            begin
                rev_next = (duty >= pt_duty_reg[3]);
                if (low_off_next)
                    ref_next = low_off_speed_reg;
                else if (up_off_next)
                    ref_next = up_off_speed_reg;
                else if (duty < pt_duty_reg[0])
                    ref_next = low_clamp_speed_reg;
                else if (duty < pt_duty_reg[1])
                    ref_next = spsel_interp(duty, pt_duty_reg[0], pt_duty_reg[1],
                        pt_speed_reg[0], pt_speed_reg[1]);
                else if (duty <= pt_duty_reg[2])
                    ref_next = pt_speed_reg[1];
                else if (duty <= pt_duty_reg[4])
                    off_next = 1'b1;
                else if (duty <= pt_duty_reg[5])
                    ref_next = pt_speed_reg[4];
                else if (duty < pt_duty_reg[6])
                    ref_next = spsel_interp(duty, pt_duty_reg[5], pt_duty_reg[6],
                        pt_speed_reg[4], pt_speed_reg[6]);
                else
                    ref_next = pt_speed_reg[6];
            end
            default:
                ref_next = `SPSEL_ZERO16;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            speed_ref_o <= `SPSEL_ZERO16;
            reverse_o <= 1'b0;
            motor_off_o <= 1'b1;
            low_off_reg <= 1'b1;
            up_off_reg <= 1'b0;
        end
        else
        begin
            speed_ref_o <= off_next ? (low_off_next ? low_off_speed_reg :
                (up_off_next ? up_off_speed_reg : `SPSEL_ZERO16)) : ref_next;
            reverse_o <= rev_next;
            motor_off_o <= off_next;
            low_off_reg <= low_off_next;
            up_off_reg <= up_off_next;
        end
    end

    // Start path sequencer
    always @*
    begin
        st_next = st_reg;
        case (st_reg)
            `SPSEL_ST_IDLE:
                if (start_i & ~motor_off_o)
                    st_next = ctrl_reg[`SPSEL_B_ISD] ? `SPSEL_ST_DETECT :
                        (ctrl_reg[`SPSEL_B_BRAKE] ? `SPSEL_ST_WAITSTOP : `SPSEL_ST_INIT);
            `SPSEL_ST_DETECT:
                if (detect_done_i)
                begin
                    if (motor_state_i == `SPSEL_MOT_FWD && ctrl_reg[`SPSEL_B_RESYNC])
                        st_next = `SPSEL_ST_CLOSED;
                    else if (motor_state_i == `SPSEL_MOT_STOP)
                        st_next = `SPSEL_ST_INIT;
                    else
                        st_next = `SPSEL_ST_WAITSTOP;
                end
            `SPSEL_ST_WAITSTOP:
                if (motor_stopped_i)
                    st_next = `SPSEL_ST_INIT;
            `SPSEL_ST_INIT:
                if (init_done_i)
                    st_next = `SPSEL_ST_OPENLOOP;
            `SPSEL_ST_OPENLOOP:
                if (handoff_i)
                    st_next = `SPSEL_ST_CLOSED;
            `SPSEL_ST_CLOSED:
                st_next = `SPSEL_ST_CLOSED;
            default:
                st_next = `SPSEL_ST_IDLE;
        endcase
        if (~start_i | motor_off_o)
            st_next = `SPSEL_ST_IDLE;
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_reg <= `SPSEL_ST_IDLE;
            start_state_o <= `SPSEL_ST_IDLE;
            brake_o <= 1'b0;
            init_method_o <= 2'h0;
        end
        else
        begin
            st_reg <= st_next;
            start_state_o <= st_next;
            brake_o <= (st_next == `SPSEL_ST_WAITSTOP) & ctrl_reg[`SPSEL_B_BRAKE];
            init_method_o <= ctrl_reg[`SPSEL_F_INIT_HI:`SPSEL_F_INIT_LO];
        end
    end
endmodule

// *** testbench/spsel_asserts.sv ***
// Checker for spsel_top: bus handshake, wake and start sequencer.
// Assumes binding into spsel_top; sees its ports only.
`timescale 1ns/1ns
`include "spsel_consts.vh"
module spsel_asserts
(
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire [31:0] wb_dat_o,
    // Wake and sequencer
    input wire speed_wake_pin_i,
    input wire standby_o,
    input wire start_i,
    input wire detect_done_i,
    input wire [1:0] motor_state_i,
    input wire motor_stopped_i,
    input wire init_done_i,
    input wire [2:0] start_state_o,
    input wire brake_o,
    input wire motor_off_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    wake_standby_a: assert property ($rose(standby_o) |-> $past(speed_wake_pin_i, 3) &&
        $past(speed_wake_pin_i, 4))
        else $error("standby without wake pin");
    resync_fwd_a: assert property ($past(start_state_o) == `SPSEL_ST_DETECT &&
        start_state_o == `SPSEL_ST_CLOSED |-> $past(motor_state_i) == `SPSEL_MOT_FWD)
        else $error("closed loop from detect without forward spin");
    open_loop_a: assert property (start_state_o == `SPSEL_ST_INIT && init_done_i &&
        start_i && !motor_off_o |=> start_state_o == `SPSEL_ST_OPENLOOP)
        else $error("init done without open loop");
    brake_wait_a: assert property (brake_o |-> start_state_o == `SPSEL_ST_WAITSTOP)
        else $error("brake outside wait for stop");
    wait_exit_a: assert property (start_state_o == `SPSEL_ST_WAITSTOP &&
        motor_stopped_i && start_i && !motor_off_o |=> start_state_o == `SPSEL_ST_INIT)
        else $error("stopped motor not started as stationary");
    cover property (start_state_o == `SPSEL_ST_CLOSED);
    cover property (start_state_o == `SPSEL_ST_OPENLOOP);
    cover property ($rose(standby_o));
endmodule
bind spsel_top spsel_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .speed_wake_pin_i(speed_wake_pin_i), .standby_o(standby_o), .start_i(start_i),
    .detect_done_i(detect_done_i), .motor_state_i(motor_state_i),
    .motor_stopped_i(motor_stopped_i), .init_done_i(init_done_i),
    .start_state_o(start_state_o), .brake_o(brake_o), .motor_off_o(motor_off_o));

// *** testbench/spsel_motor_model.sv ***
// Motor and detection model answering the start sequencer.
// Assumes the sequencer state arrives on the same clock.
`timescale 1ns/1ns
`include "spsel_consts.vh"
module spsel_motor_model
(
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Scenario control
    input wire slow_i,
    input wire [1:0] spin_i,
    // Sequencer side
    input wire [2:0] state_i,
    output wire detect_done_o,
    output wire [1:0] motor_state_o,
    output wire motor_stopped_o,
    output wire init_done_o,
    output wire handoff_o
);
    reg [2:0] last_reg;
    reg [3:0] age_reg;
    wire ready;
    // Slow mode holds every answer back several cycles
    // Age is stale in the first cycle of a new state, so that cycle never answers
    assign ready = (state_i == last_reg) && (age_reg >= (slow_i ? 4'h6 : 4'h1));
    always @(posedge clk_i)
    begin
        last_reg <= state_i;
        if (rst_i || state_i != last_reg)
            age_reg <= 4'h0;
        else if (age_reg != 4'hf)
            age_reg <= age_reg + 4'h1;
    end
    assign detect_done_o = ready && state_i == `SPSEL_ST_DETECT;
    // Direction only valid beside detect done; scrambled otherwise
    assign motor_state_o = detect_done_o ? spin_i : ~spin_i;
    assign motor_stopped_o = ready && state_i == `SPSEL_ST_WAITSTOP;
    assign init_done_o = ready && state_i == `SPSEL_ST_INIT;
    assign handoff_o = ready && state_i == `SPSEL_ST_OPENLOOP;
endmodule

// *** testbench/spsel_top_tb_top.sv ***
// Self-checking bench for spsel_top: bus, profiles, serial, wake, start paths.
// Assumes the motor model answers the start sequencer.
`timescale 1ns/1ns
`include "spsel_consts.vh"
module spsel_top_tb_top;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc = 1'b0;
    reg stb = 1'b0;
    reg we = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [31:0] wdat = 32'h0;
    reg [31:0] junk;
    reg [15:0] duty = 16'h0000;
    reg wake = 1'b0;
    reg sleep = 1'b0;
    reg start = 1'b0;
    reg slow = 1'b0;
    reg [1:0] spin = 2'h0;
    wire [31:0] rdat;
    wire ack, dd, mstop, idone, hoff, rev, off, stby, brk;
    wire [15:0] spd;
    wire [1:0] mst, im;
    wire [2:0] st;
    integer fails = 0;
    integer num_checks = 0;
    // Start cases: control, spin, states visited, brake seen
    localparam [44:0] seq_ctrl = {9'h030, 9'h070, 9'h010, 9'h020, 9'h060};
    localparam [9:0] seq_spin = {2'h1, 2'h2, 2'h1, 2'h2, 2'h1};
    localparam [39:0] seq_path = {8'h23, 8'h3f, 8'h39, 8'h3f, 8'h3f};
    localparam [4:0] seq_brk = 5'b01001;
    initial forever #4 clk_i = ~clk_i;
    spsel_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pin_duty_i(duty), .speed_wake_pin_i(wake), .sleep_i(sleep), .start_i(start),
        .detect_done_i(dd), .motor_state_i(mst), .motor_stopped_i(mstop),
        .init_done_i(idone), .handoff_i(hoff), .speed_ref_o(spd), .reverse_o(rev),
        .motor_off_o(off), .standby_o(stby), .start_state_o(st), .brake_o(brk),
        .init_method_o(im));
    spsel_motor_model motor (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .spin_i(spin),
        .state_i(st), .detect_done_o(dd), .motor_state_o(mst), .motor_stopped_o(mstop),
        .init_done_o(idone), .handoff_o(hoff));
    task conclude;
    begin
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
        num_checks = num_checks + 1;
        if (g !== e)
        begin
            fails = fails + 1;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    end
    endtask
    task limit(input integer n, input integer max);
    begin
        if (n >= max)
        begin
            fails = fails + 1;
            $display("unexpected wait length: expected below %0d, seen %0d", max, n);
            conclude;
        end
    end
    endtask
    task wb(input w, input [7:0] a, input [31:0] d, output [31:0] r);
        integer n;
    begin
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            n = n + 1;
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        limit(n, 50);
    end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        wb(1'b1, a, d, junk);
    endtask
    // Expected value packs reverse, off, then speed
    task pt(input [15:0] d, input [17:0] e);
    begin
        @(posedge clk_i);
        duty <= d;
        repeat (4) @(posedge clk_i);
        chk("direction, off, speed", 32'(e), 32'({rev, off, spd}));
    end
    endtask
    task t_bus;
        integer i;
    begin
        wb(1'b0, `SPSEL_ADR_CTRL, 32'h0, junk);
        chk("control reset", {23'h0, `SPSEL_CTRL_RST}, junk);
        wr(8'hfc, 32'hffff_ffff);
        wb(1'b0, 8'hfc, 32'h0, junk);
        chk("unmapped read", 32'h0, junk);
        wr(`SPSEL_ADR_LOW, 32'h1800_1000);
        wr(`SPSEL_ADR_LOWSPD, 32'h0100_0011);
        wr(`SPSEL_ADR_UP, 32'hd000_e000);
        wr(`SPSEL_ADR_UPSPD, 32'h0000_0022);
        for (i = 0; i < `SPSEL_NPTS; i = i + 1)
            wr(`SPSEL_ADR_PT0 + 8'(4 * i),
                {(i == 0) ? 16'h0100 : 16'(i * 512), 16'h2000 + 16'(i * 4096)});
        wb(1'b0, `SPSEL_ADR_LOW, 32'h0, junk);
        chk("lower duty pair", 32'h1800_1000, junk);
    end
    endtask
    task t_lin;
    begin
        wr(`SPSEL_ADR_CTRL, 32'h0);
        pt(16'h3800, 18'h00300);
        pt(16'h5800, 18'h00700);
        pt(16'h9000, 18'h00c00);
    end
    endtask
    task t_hyst;
    begin
        pt(16'h0800, 18'h10011);
        pt(16'h1400, 18'h10011);
        pt(16'h1c00, 18'h00100);
        pt(16'hf000, 18'h10022);
        pt(16'hd800, 18'h10022);
        pt(16'hc000, 18'h00c00);
    end
    endtask
    task t_stair;
    begin
        wr(`SPSEL_ADR_CTRL, 32'h4);
        pt(16'h3800, 18'h00200);
        chk("stair step", 32'h1, 32'(spd == 16'h0200 || spd == 16'h0400));
    end
    endtask
    task t_fr;
    begin
        wr(`SPSEL_ADR_CTRL, 32'h8);
        pt(16'h2800, 18'h00180);
        pt(16'h3800, 18'h00200);
        pt(16'h4800, 18'h10000);
        chk("forward off", 32'h1, 32'(off));
        pt(16'h6800, 18'h20800);
        pt(16'h7800, 18'h20a00);
    end
    endtask
    task t_ser;
    begin
        wr(`SPSEL_ADR_CTRL, 32'h1);
        wr(`SPSEL_ADR_DIGSPD, 32'h3800);
        pt(16'h9000, 18'h00300);
        wr(`SPSEL_ADR_CTRL, 32'h0);
        pt(16'h9000, 18'h00c00);
    end
    endtask
    task t_seq;
        reg [7:0] seen;
        reg bs;
        reg [1:0] ims;
        integer i, n;
    begin
        for (i = 0; i < 5; i = i + 1)
        begin
            wr(`SPSEL_ADR_CTRL, {23'h0, seq_ctrl[9 * i +: 9] | (9'(i % 4) << 7)});
            @(posedge clk_i);
            spin <= seq_spin[2 * i +: 2];
            slow <= (i % 2 == 1);
            start <= 1'b1;
            seen = 8'h00;
            bs = 1'b0;
            ims = 2'h0;
            n = 0;
            while (st !== `SPSEL_ST_CLOSED && n < 100)
            begin
                @(posedge clk_i);
                seen[st] = 1'b1;
                bs = bs | brk;
                if (st == `SPSEL_ST_INIT)
                    ims = im;
                n = n + 1;
            end
            limit(n, 100);
            chk("start path", 32'(seq_path[8 * i +: 8]), 32'(seen | 8'h01));
            chk("brake seen", 32'(seq_brk[i]), 32'(bs));
            if (i < 4)
                chk("init method", 32'(i), 32'(ims));
            start <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    end
    endtask
    task t_wake;
        integer n;
    begin
        wr(`SPSEL_ADR_CTRL, 32'h3);
        @(posedge clk_i);
        sleep <= 1'b1;
        wake <= 1'b1;
        n = 0;
        while (stby !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n = n + 1;
        end
        limit(n, 20);
        chk("standby", 32'h1, 32'(stby));
        pt(16'h1400, 18'h00300);
    end
    endtask
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_bus;
        t_lin;
        t_hyst;
        t_stair;
        t_fr;
        t_ser;
        t_seq;
        t_wake;
        conclude;
    end
endmodule
